// ==== logic/crc_console.sv ====
// Console run-control logic with APB access to its toggles and status.
`default_nettype none
module crc_console
   import crc_pkg::*;
#(
   parameter int unsigned ADV_CNT = ADV_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire crc_mom_t mom_pin,
   input wire crc_lock_t lock_pin,
   input wire logic tw_strobe_pin,
   input wire logic [CHAR_W-1:0] tw_char_pin,
   input wire logic cpu_done,
   input wire logic cpu_tagged,
   input wire logic cpu_xfer_busy,
   input wire logic cpu_instr_err,
   input wire logic [N_ERR-1:0] cpu_err_evt,
   input wire logic cpu_err_lvl,
   input wire logic uri_err_lvl,
   input wire logic boot_done,
   output logic cpu_fetch,
   output logic cpu_exec_ir,
   output logic cpu_abort,
   output logic clr_acc,
   output logic iar_load,
   output logic [ADDR_W-1:0] iar_val,
   output logic boot_start,
   output logic [2:0] device_select_field,
   output logic mem_we,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [WORD_W-1:0] mem_wdata,
   output logic [WORD_W-1:0] ir_word,
   output logic [WORD_W-1:0] r_word,
   output logic opint_req,
   output logic [N_ERR-1:0] err_irq,
   output logic print_nop,
   output logic kb_unlock,
   output crc_lock_t lock_lamp,
   output logic halt_lamp,
   output logic start_lamp,
   output logic step_lamp,
   output logic store_lamp,
   output logic clear_lamp,
   output logic card_lamp,
   output logic tape_lamp,
   output logic errclr_lamp,
   output logic sel_ir_lamp,
   output logic sel_r_lamp,
   output logic auto_lamp,
   output logic [N_ERR-1:0] ign_lamp
);
   // =========================================================
   // Pin synchronisers and press detection
   // =========================================================
   localparam int MW = $bits(crc_mom_t);
   localparam int LW = $bits(crc_lock_t);
   localparam int TW = MW + LW + 1 + CHAR_W;
   logic [TW-1:0] sy1_q;
   logic [TW-1:0] sy2_q;
   logic [MW+LW:0] old_q;
   crc_mom_t mom_lvl;
   crc_mom_t mp;
   crc_lock_t lock_lvl;
   crc_lock_t lock_prs;
   crc_lock_t lock_q;
   logic tw_lvl;
   logic tw_prs;
   logic [CHAR_W-1:0] tw_chr;

   // Two flops per pin; the first stage feeds only the second.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sy1_q <= '0;
         sy2_q <= '0;
         old_q <= '0;
      end else if (ce) begin
         sy1_q <= {mom_pin, lock_pin, tw_strobe_pin, tw_char_pin};
         sy2_q <= sy1_q;
         old_q <= sy2_q[TW-1:CHAR_W];
      end
   end

   // Rising edges of the synchronised levels become one-cycle pulses.
   // single press pulse
   assign mom_lvl = crc_mom_t'(sy2_q[TW-1 -: MW]);
   assign lock_lvl = crc_lock_t'(sy2_q[CHAR_W+LW : CHAR_W+1]);
   assign tw_lvl = sy2_q[CHAR_W];
   assign tw_chr = sy2_q[CHAR_W-1:0];
   assign mp = crc_mom_t'(mom_lvl & ~old_q[MW+LW -: MW] & {MW{ce}});
   assign lock_prs = crc_lock_t'(lock_lvl & ~old_q[LW:1] & {LW{ce}});
   assign tw_prs = tw_lvl & ~old_q[0] & ce;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_q <= '0;
      end else begin
         lock_q <= lock_q ^ lock_prs;
      end
   end

   // =========================================================
   // APB decode
   // =========================================================
   logic wr;
   logic rd_setup;
   logic mapped;
   logic [9:0] ctrl_q;
   logic [N_ERR-1:0] derr_q;
   logic opint_q;
   logic [ADDR_W-1:0] oar_q;
   crc_state_t st_q;
   logic sel_ir_q;
   logic sel_r_q;

   assign mapped = paddr == OFS_CTRL || paddr == OFS_STAT || paddr == OFS_ERR
                   || paddr == OFS_OADR;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr = psel & penable & pwrite & mapped & ce;
   assign rd_setup = psel & ~penable & ~pwrite & ce;

   // Read data is captured in the setup cycle and shown in the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_setup) begin
         case (paddr)
            OFS_CTRL: prdata <= {22'h000000, ctrl_q};
            OFS_STAT: prdata <= {17'h00000, sel_r_q, sel_ir_q, st_q == ST_HALT, lock_q.inh,
                                 lock_q.adv, lock_q.tag, lock_q.brk};
            OFS_ERR: prdata <= {23'h000000, opint_q, derr_q};
            OFS_OADR: prdata <= {16'h0000, oar_q};
            default: prdata <= '0;
         endcase
      end
   end

   // =========================================================
   // Error mode and ignore toggles
   // =========================================================
   // ignore toggles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
      end else begin
         ctrl_q <= ((wr && paddr == OFS_CTRL) ? pwdata[9:0] : ctrl_q)
                   ^ {1'b0, mp.err_mode, mp.ign};
      end
   end

   // Detail error toggles; a new error wins over the clear.
   // clear all details
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         derr_q <= '0;
      end else if (ce) begin
         derr_q <= (mp.err_clear ? '0 : derr_q) | cpu_err_evt;
      end
   end

   // Operator interrupt detail toggle, cleared by writing one.
   // operator interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opint_q <= 1'b0;
      end else begin
         opint_q <= (opint_q & ~(wr && paddr == OFS_ERR && pwdata[ERR_OPINT])) | mp.opint;
      end
   end

   assign err_irq = ctrl_q[CTRL_AUTO] ? derr_q & ~ctrl_q[N_ERR-1:0] : '0;
   assign opint_req = opint_q;

   // =========================================================
   // Run/halt sequencer
   // =========================================================
   logic halted;
   logic busy_q;
   logic stop_q;
   logic [23:0] adv_q;
   logic adv_ok;
   logic boot_ok;
   logic err_halt;

   assign halted = st_q == ST_HALT;
   assign adv_ok = ~lock_q.adv || adv_q == '0;
   assign boot_ok = ~cpu_err_lvl & ~uri_err_lvl;
   assign err_halt = (~ctrl_q[CTRL_AUTO] & |cpu_err_evt)
                     | (cpu_instr_err & ctrl_q[CTRL_MIGN]);

   // Pacing counter for advance mode, reloaded at each completion.
   // one per second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adv_q <= '0;
      end else if (ce) begin
         if (cpu_done) begin
            adv_q <= 24'(ADV_CNT - 1);
         end else if (adv_q != '0) begin
            adv_q <= adv_q - 24'h000001;
         end
      end
   end

   // Stop request, taken at the end of the current instruction.
   // halt after instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= 1'b0;
      end else if (ce) begin
         if (halted) begin
            stop_q <= 1'b0;
         end else if (mp.halt || err_halt) begin
            stop_q <= 1'b1;
         end
      end
   end

   // Main sequencer with the pulses it issues toward the processor.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_HALT;
         busy_q <= 1'b0;
         cpu_fetch <= 1'b0;
         cpu_exec_ir <= 1'b0;
         cpu_abort <= 1'b0;
         iar_load <= 1'b0;
         boot_start <= 1'b0;
         device_select_field <= '0;
      end else if (ce) begin
         cpu_fetch <= 1'b0;
         cpu_exec_ir <= 1'b0;
         cpu_abort <= 1'b0;
         iar_load <= 1'b0;
         boot_start <= 1'b0;
         case (st_q)
            ST_HALT: begin
               if (mp.start) begin
                  st_q <= ST_RUN;
               end else if (mp.step) begin
                  st_q <= ST_STEP;
                  cpu_fetch <= 1'b1;
               end else if (mp.exec) begin
                  st_q <= ST_EXEC;
                  cpu_exec_ir <= 1'b1;
               end else if (mp.ld_card && boot_ok) begin
                  st_q <= ST_BOOT;
                  boot_start <= 1'b1;
                  device_select_field <= CARD_TRUNK;
               end else if (mp.ld_tape && boot_ok) begin
                  st_q <= ST_BOOT;
                  boot_start <= 1'b1;
                  device_select_field <= TAPE_TRUNK;
               end
            end
            ST_RUN: begin
               if (mp.clear) begin
                  st_q <= ST_HALT;
                  busy_q <= 1'b0;
                  cpu_abort <= 1'b1;
               end else if (cpu_done) begin
                  busy_q <= 1'b0;
                  if (stop_q || err_halt || mp.halt || (cpu_tagged && lock_q.tag)) begin
                     st_q <= ST_DRAIN;
                  end
               end else if (!busy_q && adv_ok) begin
                  busy_q <= 1'b1;
                  cpu_fetch <= 1'b1;
               end
            end
            ST_STEP, ST_EXEC: begin
               if (mp.clear) begin
                  st_q <= ST_HALT;
                  cpu_abort <= 1'b1;
               end else if (cpu_done) begin
                  st_q <= ST_DRAIN;
               end
            end
            ST_DRAIN: begin
               if (!cpu_xfer_busy) begin
                  st_q <= ST_HALT;
               end
            end
            ST_BOOT: begin
               if (mp.clear) begin
                  st_q <= ST_HALT;
                  cpu_abort <= 1'b1;
               end else if (boot_done) begin
                  st_q <= ST_RUN;
                  iar_load <= 1'b1;
               end
            end
            default: st_q <= ST_HALT;
         endcase
      end
   end

   assign iar_val = BOOT_ADDR;

   // =========================================================
   // Store, clear and typewriter entry
   // =========================================================
   logic [3:0] cnt_q;
   logic [WORD_W-1:0] ir_q;
   logic [WORD_W-1:0] r_q;
   logic ent_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oar_q <= '0;
         mem_we <= 1'b0;
         mem_addr <= '0;
         mem_wdata <= '0;
      end else if (ce) begin
         mem_we <= 1'b0;
         if (halted && mp.store) begin
            mem_we <= 1'b1;
            mem_addr <= oar_q;
            mem_wdata <= r_q;
            oar_q <= oar_q + 16'h0001;
         end else if (wr && paddr == OFS_OADR) begin
            oar_q <= pwdata[ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_ir_q <= 1'b0;
         sel_r_q <= 1'b0;
      end else if (mp.ent_ir) begin
         sel_ir_q <= 1'b1;
         sel_r_q <= 1'b0;
      end else if (mp.ent_r) begin
         sel_ir_q <= 1'b0;
         sel_r_q <= 1'b1;
      end
   end

   assign ent_ok = halted & tw_prs;

   // Character shift registers; a ninth character restarts the word.
   // ninth discards eight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         ir_q <= '0;
         r_q <= '0;
         clr_acc <= 1'b0;
      end else if (ce) begin
         clr_acc <= 1'b0;
         if (mp.ent_ir || mp.ent_r) begin
            cnt_q <= '0;
         end else if (halted && mp.clear) begin
            r_q <= '0;
            clr_acc <= 1'b1;
         end else if (ent_ok && (sel_ir_q || sel_r_q)) begin
            cnt_q <= (cnt_q == 4'(REG_CHARS)) ? 4'h1 : cnt_q + 4'h1;
            if (sel_ir_q) begin
               ir_q <= (cnt_q == 4'(REG_CHARS)) ? WORD_W'(tw_chr) : {ir_q[WORD_W-CHAR_W-1:0], tw_chr};
            end else begin
               r_q <= (cnt_q == 4'(REG_CHARS)) ? WORD_W'(tw_chr) : {r_q[WORD_W-CHAR_W-1:0], tw_chr};
            end
         end
      end
   end

   // =========================================================
   // Lamps and level outputs
   // =========================================================
   assign ir_word = ir_q;
   assign r_word = r_q;
   assign print_nop = lock_q.inh;
   assign kb_unlock = halted & (sel_ir_q | sel_r_q);
   assign lock_lamp = lock_q;
   assign halt_lamp = halted;
   assign start_lamp = ~halted;
   assign step_lamp = mom_lvl.step;
   assign store_lamp = mom_lvl.store;
   assign clear_lamp = mom_lvl.clear;
   assign card_lamp = mom_lvl.ld_card;
   assign tape_lamp = st_q == ST_BOOT && device_select_field == TAPE_TRUNK;
   assign errclr_lamp = mom_lvl.err_clear;
   assign sel_ir_lamp = sel_ir_q;
   assign sel_r_lamp = sel_r_q;
   assign auto_lamp = ctrl_q[CTRL_AUTO];
   assign ign_lamp = ctrl_q[N_ERR-1:0];

   // =========================================================
   // Assertions
   // =========================================================
   property p_boot_block;
      @(posedge pclk) disable iff (!presetn)
      (mp.ld_card | mp.ld_tape) && !boot_ok |=> !boot_start;
   endproperty
   a_boot_block: assert property (p_boot_block) else $error("boot taken under error");

   property p_store;
      @(posedge pclk) disable iff (!presetn)
      halted && mp.store |=> mem_we && oar_q == mem_addr + 16'h0001 && mem_wdata == $past(r_q);
   endproperty
   a_store: assert property (p_store) else $error("store did not count up");

   property p_start;
      @(posedge pclk) disable iff (!presetn)
      mp.start && !halted && st_q != ST_DRAIN |=> $stable(start_lamp) || halt_lamp;
   endproperty
   a_start: assert property (p_start) else $error("start acted while running");

   property p_clear_run;
      @(posedge pclk) disable iff (!presetn)
      mp.clear && st_q == ST_RUN |=> halted && cpu_abort && $stable(r_q);
   endproperty
   a_clear_run: assert property (p_clear_run) else $error("clear while running wrong");

   property p_opint;
      @(posedge pclk) disable iff (!presetn)
      mp.opint |=> opint_req;
   endproperty
   a_opint: assert property (p_opint) else $error("operator request lost");

   property p_ninth;
      @(posedge pclk) disable iff (!presetn)
      ce && ent_ok && sel_r_q && cnt_q == 4'h8 && !mp.ent_ir && !mp.ent_r && !mp.clear
      |=> r_q == WORD_W'($past(tw_chr)) && cnt_q == 4'h1;
   endproperty
   a_ninth: assert property (p_ninth) else $error("ninth character kept old word");

   property p_adv;
      @(posedge pclk) disable iff (!presetn)
      cpu_fetch && st_q == ST_RUN && lock_q.adv |-> $past(adv_q) == '0;
   endproperty
   a_adv: assert property (p_adv) else $error("advance paced wrongly");

   property p_tag;
      @(posedge pclk) disable iff (!presetn)
      ce && st_q == ST_RUN && cpu_done && cpu_tagged && lock_q.tag && !mp.clear
      |=> st_q == ST_DRAIN;
   endproperty
   a_tag: assert property (p_tag) else $error("tagged instruction did not halt");

   property p_errclr;
      @(posedge pclk) disable iff (!presetn)
      mp.err_clear && cpu_err_evt == '0 |=> derr_q == '0;
   endproperty
   a_errclr: assert property (p_errclr) else $error("error clear missed");

   property p_sel;
      @(posedge pclk) disable iff (!presetn)
      !(sel_ir_q && sel_r_q);
   endproperty
   a_sel: assert property (p_sel) else $error("both entry selects lit");

endmodule : crc_console
`default_nettype wire

// ==== pkg/crc_pkg.sv ====
// Constants, carriers and register map for the console run-control block.
// What this block does
// - Locking buttons toggle on each press; the lamp shows the latched state.
// - Operator interrupt press raises a request and sets a toggle program clears.
// - Nine latching breakpoint switches, each readable by program.
// - With tag latched, halt after any tagged instruction; tag readable.
// - Start works only in halt; its lamp stays on until halt returns.
// - Advance latched runs about one instruction per second, in run state only.
// - Step in halt fetches, executes, advances address, halts; lamp while held.
// - Halt stops after current instruction; transfers finish; lamp while halted.
// - Store in halt writes operand word at operand address, then adds one.
// - Execute in halt runs the instruction register as if fetched.
// - Two entry selects are exclusive, stay lit, entry works only in halt.
// - Entry fills eight characters; a ninth discards the eight held.
// - Clear in halt zeroes accumulator and operand word; running, it halts.
// - Load cards in halt boots from card trunk at twenty, then runs.
// - Load tape in halt boots from tape trunk at twenty, then runs.
// - Both load buttons ignored while computer or interface error present.
// - Eight ignore toggles, by button or program, block only the interrupt.
// - Inhibit printout latched makes print a no-operation; lamp shows it.
// - Error mode button toggles; manual halts on error, auto interrupts.
// - Instruction error while master ignore is set always halts.
// - Error clear resets all detail error toggles; lamp while held.
`default_nettype none
package crc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned ADV_PERIOD_MS = 1000;
   localparam int unsigned ADV_CYCLES = ADV_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int N_BRK = 9;
   localparam int N_ERR = 8;
   localparam int REG_CHARS = 8;
   localparam int CHAR_W = 6;
   localparam int WORD_W = REG_CHARS * CHAR_W;
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] BOOT_ADDR = 16'h0014;
   localparam logic [2:0] CARD_TRUNK = 3'h2;
   localparam logic [2:0] TAPE_TRUNK = 3'h0;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STAT = 12'h004;
   localparam logic [11:0] OFS_ERR = 12'h008;
   localparam logic [11:0] OFS_OADR = 12'h00C;
   localparam int CTRL_AUTO = 8;
   localparam int CTRL_MIGN = 9;
   localparam int STAT_TAG = 9;
   localparam int STAT_ADV = 10;
   localparam int STAT_INH = 11;
   localparam int STAT_HALT = 12;
   localparam int STAT_SEL_IR = 13;
   localparam int STAT_SEL_R = 14;
   localparam int ERR_OPINT = 8;
   localparam logic [9:0] CTRL_RESET = 10'h000;
   typedef enum {ST_HALT, ST_RUN, ST_STEP, ST_EXEC, ST_DRAIN, ST_BOOT} crc_state_t;
   typedef struct packed {
      logic opint;
      logic start;
      logic step;
      logic halt;
      logic store;
      logic exec;
      logic ent_ir;
      logic ent_r;
      logic clear;
      logic ld_card;
      logic ld_tape;
      logic err_mode;
      logic err_clear;
      logic [N_ERR-1:0] ign;
   } crc_mom_t;
   typedef struct packed {
      logic [N_BRK-1:0] brk;
      logic tag;
      logic adv;
      logic inh;
   } crc_lock_t;
endpackage : crc_pkg
`default_nettype wire

// ==== dv/crc_panel.sv ====
// Behavioural operator panel and console typewriter feeding the console block.
`default_nettype none
module crc_panel
   import crc_pkg::*;
(
   input wire logic pclk,
   output crc_mom_t mom_pin,
   output crc_lock_t lock_pin,
   output logic tw_strobe_pin,
   output logic [CHAR_W-1:0] tw_char_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Panel starts with every button up and the typewriter quiet.
   initial begin
      mom_pin = '0;
      lock_pin = '0;
      tw_strobe_pin = 1'b0;
      tw_char_pin = '1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // A press is held two cycles, then released long enough to settle.
   task automatic press_mom(input crc_mom_t m);
      @(posedge pclk);
      mom_pin <= m;
      hold(2);
      mom_pin <= '0;
      hold(6);
   endtask
   task automatic press_lock(input crc_lock_t l);
      @(posedge pclk);
      lock_pin <= l;
      hold(2);
      lock_pin <= '0;
      hold(6);
   endtask
   // six-bit code
   // Character is steady around the strobe; afterwards the line shows junk.
   task automatic type_char(input logic [CHAR_W-1:0] c);
      @(posedge pclk);
      tw_char_pin <= c;
      hold(2);
      tw_strobe_pin <= 1'b1;
      hold(2);
      tw_strobe_pin <= 1'b0;
      hold(4);
      tw_char_pin <= ~c;
      hold(4);
   endtask
endmodule // crc_panel
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking testbench for the console run-control block.
`default_nettype none
module tb_top
   import crc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int B_OPI = 20, B_STA = 19, B_STP = 18, B_HLT = 17, B_STO = 16, B_EXE = 15;
   localparam int B_EIR = 14, B_ER = 13, B_CLR = 12, B_CRD = 11, B_TAP = 10, B_MOD = 9, B_EC = 8;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, cpu_done = 1'b0, cpu_err_lvl = 1'b0, boot_done = 1'b0;
   logic cpu_tagged = 1'b0, cpu_xfer_busy = 1'b0, cpu_instr_err = 1'b0, uri_err_lvl = 1'b0;
   logic [N_ERR-1:0] cpu_err_evt = '0, err_irq, ign_lamp;
   crc_mom_t mom_pin;
   crc_lock_t lock_pin, lock_lamp, lk;
   logic tw_strobe_pin, cpu_fetch, cpu_exec_ir, cpu_abort, clr_acc, boot_start, mem_we;
   logic [CHAR_W-1:0] tw_char_pin;
   logic [ADDR_W-1:0] iar_val, mem_addr, st_addr;
   logic [2:0] device_select_field;
   logic [WORD_W-1:0] mem_wdata, ir_word, r_word, st_data, exp;
   logic opint_req, print_nop, halt_lamp, start_lamp, sel_ir_lamp, sel_r_lamp, auto_lamp;
   int n_errors = 0, checked = 0, n_fetch = 0, n_exec = 0, n_abort = 0, n_clr = 0;
   int n_boot = 0, n_we = 0, f0;
   always #50 pclk = ~pclk;
   crc_panel pnl (.pclk(pclk), .mom_pin(mom_pin), .lock_pin(lock_pin),
      .tw_strobe_pin(tw_strobe_pin), .tw_char_pin(tw_char_pin));
   crc_console #(.ADV_CNT(8)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mom_pin(mom_pin), .lock_pin(lock_pin),
      .tw_strobe_pin(tw_strobe_pin), .tw_char_pin(tw_char_pin), .cpu_done(cpu_done),
      .cpu_tagged(cpu_tagged), .cpu_xfer_busy(cpu_xfer_busy), .cpu_instr_err(cpu_instr_err),
      .cpu_err_evt(cpu_err_evt), .cpu_err_lvl(cpu_err_lvl), .uri_err_lvl(uri_err_lvl),
      .boot_done(boot_done),
      .cpu_fetch(cpu_fetch), .cpu_exec_ir(cpu_exec_ir), .cpu_abort(cpu_abort),
      .clr_acc(clr_acc), .iar_load(), .iar_val(iar_val), .boot_start(boot_start),
      .device_select_field(device_select_field), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .ir_word(ir_word), .r_word(r_word), .opint_req(opint_req),
      .err_irq(err_irq), .print_nop(print_nop), .kb_unlock(), .lock_lamp(lock_lamp),
      .halt_lamp(halt_lamp), .start_lamp(start_lamp), .step_lamp(), .store_lamp(),
      .clear_lamp(), .card_lamp(), .tape_lamp(), .errclr_lamp(), .sel_ir_lamp(sel_ir_lamp),
      .sel_r_lamp(sel_r_lamp), .auto_lamp(auto_lamp), .ign_lamp(ign_lamp));
   // Counts the one-cycle pulses and keeps what a memory write carried.
   always @(posedge pclk) begin
      n_fetch += (cpu_fetch === 1'b1);
      n_exec += (cpu_exec_ir === 1'b1);
      n_abort += (cpu_abort === 1'b1);
      n_clr += (clr_acc === 1'b1);
      n_boot += (boot_start === 1'b1);
      if (mem_we === 1'b1) begin
         n_we++;
         st_addr = mem_addr;
         st_data = mem_wdata;
      end
   end
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         n_errors++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pm(input int b);
      crc_mom_t m;
      m = '0;
      m[b] = 1'b1;
      pnl.press_mom(m);
   endtask
   task automatic done_pulse();
      @(posedge pclk);
      cpu_done <= 1'b1;
      @(posedge pclk);
      cpu_done <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   // Hang guard.
   initial begin
      repeat (30000) @(posedge pclk);
      n_errors++;
      end_sim();
   end
   // Main sequence.
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("halt_lamp", 1, halt_lamp);
      chk("start_lamp", 0, start_lamp);
      apb(0, OFS_CTRL, 0);
      chk("ctrl", 0, rd);
      apb(0, 12'h010, 0);
      chk("unmapped", 1, er);
      lk = '0;
      lk.tag = 1'b1;
      pnl.press_lock(lk);
      apb(0, OFS_STAT, 0);
      chk("tag_on", 1, rd[STAT_TAG]);
      chk("tag_lamp", 1, lock_lamp.tag);
      pnl.press_lock(lk);
      apb(0, OFS_STAT, 0);
      chk("tag_off", 0, rd[STAT_TAG]);
      lk = '0;
      lk.brk = '1;
      pnl.press_lock(lk);
      apb(0, OFS_STAT, 0);
      chk("brk", 9'h1FF, rd[8:0]);
      pm(B_ER);
      chk("sel_r", 1, sel_r_lamp);
      exp = '0;
      for (int c = 1; c <= 8; c++) begin
         pnl.type_char(6'(c));
         exp = (exp << CHAR_W) | 48'(c);
      end
      chk("r_8", exp, r_word);
      pnl.type_char(6'h09);
      chk("r_9", 48'h000000000009, r_word);
      pm(B_EIR);
      chk("sel_r_off", 0, sel_r_lamp);
      pnl.type_char(6'h2A);
      chk("ir", 48'h00000000002A, ir_word);
      apb(1, OFS_OADR, 32'h00000010);
      pm(B_STO);
      chk("st_n", 1, n_we);
      chk("st_addr", 16'h0010, st_addr);
      chk("st_data", 48'h000000000009, st_data);
      apb(0, OFS_OADR, 0);
      chk("oadr", 32'h00000011, rd);
      pm(B_CLR);
      chk("r_clr", 0, r_word);
      chk("acc_clr", 1, n_clr);
      cpu_err_lvl <= 1'b1;
      pm(B_CRD);
      chk("boot_blk", 0, n_boot);
      cpu_err_lvl <= 1'b0;
      uri_err_lvl <= 1'b1;
      pm(B_CRD);
      chk("boot_blk_uri", 0, n_boot);
      uri_err_lvl <= 1'b0;
      pm(B_CRD);
      chk("boot_n", 1, n_boot);
      chk("card_trunk", 3'h2, device_select_field);
      chk("iar_val", 16'h0014, iar_val);
      @(posedge pclk);
      boot_done <= 1'b1;
      @(posedge pclk);
      boot_done <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("boot_run", 1, start_lamp);
      pm(B_CLR);
      chk("abort", 1, n_abort);
      chk("clr_halt", 1, halt_lamp);
      pm(B_TAP);
      chk("tape_trunk", 3'h0, device_select_field);
      chk("tape_n", 2, n_boot);
      pm(B_CLR);
      f0 = n_fetch;
      pm(B_STA);
      chk("start_fetch", f0 + 1, n_fetch);
      chk("start_on", 1, start_lamp);
      pm(B_STA);
      chk("start_ign", f0 + 1, n_fetch);
      pm(B_HLT);
      cpu_xfer_busy <= 1'b1;
      done_pulse();
      chk("drain", 0, halt_lamp);
      cpu_xfer_busy <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("halted", 1, halt_lamp);
      chk("start_off", 0, start_lamp);
      pm(B_STP);
      chk("step_fetch", f0 + 2, n_fetch);
      done_pulse();
      chk("step_halt", 1, halt_lamp);
      pm(B_EXE);
      chk("exec", 1, n_exec);
      done_pulse();
      lk = '0;
      lk.tag = 1'b1;
      pnl.press_lock(lk);
      pm(B_STA);
      cpu_tagged <= 1'b1;
      done_pulse();
      cpu_tagged <= 1'b0;
      chk("tag_halt", 1, halt_lamp);
      apb(1, OFS_CTRL, 32'h00000200);
      pm(B_STA);
      cpu_instr_err <= 1'b1;
      done_pulse();
      cpu_instr_err <= 1'b0;
      chk("mign_halt", 1, halt_lamp);
      apb(1, OFS_CTRL, 32'h00000101);
      @(posedge pclk);
      cpu_err_evt <= 8'h03;
      @(posedge pclk);
      cpu_err_evt <= 8'h00;
      repeat (2) @(posedge pclk);
      chk("irq_ign", 8'h02, err_irq);
      apb(0, OFS_ERR, 0);
      chk("err_tgl", 8'h03, rd[7:0]);
      pm(0);
      chk("ign_lamp", 8'h00, ign_lamp);
      chk("irq_all", 8'h03, err_irq);
      pm(B_MOD);
      chk("auto_off", 0, auto_lamp);
      pm(B_EC);
      apb(0, OFS_ERR, 0);
      chk("err_clr", 0, rd);
      pm(B_OPI);
      chk("opint", 1, opint_req);
      apb(0, OFS_ERR, 0);
      chk("opint_tgl", 32'h00000100, rd);
      apb(1, OFS_ERR, 32'h00000100);
      apb(0, OFS_ERR, 0);
      chk("opint_clr", 0, rd);
      lk = '0;
      lk.inh = 1'b1;
      pnl.press_lock(lk);
      chk("print_nop", 1, print_nop);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
